/* hdl/serdes_common_pkg.sv */
// Constants, types and helpers for the common transceiver control registers
package serdes_common_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_CLOCK_SEL = 20'h30A00;
  localparam logic [ADDR_W-1:0] IDX_THRESH_LOW = 20'h30A01;
  localparam logic [ADDR_W-1:0] IDX_THRESH_HIGH = 20'h30A02;
  localparam logic [ADDR_W-1:0] IDX_ALIGN_STATUS = 20'h30A03;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 20'h30A04;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 20'h30A05;

  // Index to byte address: one aligned word per register
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int QA_TX_LSB = 0;
  localparam int QA_RX_LSB = 2;
  localparam int QB_TX_LSB = 4;
  localparam int QB_RX_LSB = 6;
  localparam int THR_LOW_LSB = 5;
  localparam int THR_LOW_W = 3;
  localparam int THR_HIGH_LSB = 0;
  localparam int THR_HIGH_W = 2;
  localparam int THR_W = 5;
  localparam int RESYNC_BIT = 2;
  localparam int OVFL_BIT = 0;
  localparam int LOST_BIT = 1;
  localparam int IRQ_OVFL_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;
  localparam int IRQ_RESYNC_BIT = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_CLOCK_SEL = 8'h00;
  localparam logic [THR_W-1:0] RST_THRESH = 5'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

  // Channel codes, low bit written first: 00 first, 10 second, 01 third, 11 fourth
  typedef enum logic [1:0] {
    CH_FIRST = 2'h0,
    CH_SECOND = 2'h1,
    CH_THIRD = 2'h2,
    CH_FOURTH = 2'h3
  } chan_sel_e;

  // Clock source selects, one register
  typedef struct packed {
    logic [1:0] quad_b_rx;
    logic [1:0] quad_b_tx;
    logic [1:0] quad_a_rx;
    logic [1:0] quad_a_tx;
  } clock_sel_s;

  // Alignment status from the channel logic
  typedef struct packed {
    logic lost;
    logic overflow;
  } align_status_s;

  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } apb_state_e;

endpackage

/* hdl/rise_detect.sv */
// Rising-edge detector with clock enable, one-cycle pulse out
`timescale 1ns/1ps
module rise_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic level,
  output logic pulse
);

  logic level_prev;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_prev <= 1'b0;
      pulse <= 1'b0;
    end else if (ce) begin
      level_prev <= level;
      pulse <= level & ~level_prev;
    end
  end

endmodule

/* hdl/serdes_common_regs.sv */
// Common clock select, FIFO threshold, resync and alignment status registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module serdes_common_regs
  import serdes_common_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire align_status_s align_in,
  output logic [1:0] quad_a_tx_clock_source_sel,
  output logic [1:0] quad_a_rx_clock_source_sel,
  output logic [1:0] quad_b_tx_clock_source_sel,
  output logic [1:0] quad_b_rx_clock_source_sel,
  output logic [THR_W-1:0] rx_fifo_low_threshold,
  output logic all_channel_resync_trigger,
  output logic all_channel_align_overflow,
  output logic all_channel_align_lost,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  apb_state_e state;
  apb_state_e next_state;
  clock_sel_s clock_sel;
  logic [THR_LOW_W-1:0] thresh_low;
  logic [THR_HIGH_W-1:0] thresh_high;
  logic resync_ctrl;
  logic ovfl_flag;
  logic lost_flag;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic resync_pulse;
  logic ovfl_prev;
  logic lost_prev;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  // First access cycle: ready and read data are launched from here
  wire start = access & (state == ST_IDLE);
  wire commit = access & pready & (state == ST_RESP);
  wire wr_en = commit & pwrite & ce;
  wire hit_clock = (paddr == byte_addr(IDX_CLOCK_SEL));
  wire hit_low = (paddr == byte_addr(IDX_THRESH_LOW));
  wire hit_high = (paddr == byte_addr(IDX_THRESH_HIGH));
  wire hit_status = (paddr == byte_addr(IDX_ALIGN_STATUS));
  wire hit_irq = (paddr == byte_addr(IDX_IRQ_STATUS));
  wire hit_mask = (paddr == byte_addr(IDX_IRQ_MASK));
  wire mapped = hit_clock | hit_low | hit_high | hit_status | hit_irq | hit_mask;
  // Status register is read-only; a write there is refused
  wire refused = ~mapped | (pwrite & hit_status);
  wire wr_clock = wr_en & hit_clock;
  wire wr_low = wr_en & hit_low;
  wire wr_high = wr_en & hit_high;
  wire wr_irq = wr_en & hit_irq;
  wire wr_mask = wr_en & hit_mask;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [REG_W-1:0] rd_clock = clock_sel;
  wire [REG_W-1:0] rd_low = {thresh_low, 5'h00};
  wire [REG_W-1:0] rd_high = {5'h00, resync_ctrl, thresh_high};
  wire [REG_W-1:0] rd_status = {6'h00, lost_flag, ovfl_flag};
  wire [REG_W-1:0] rd_irq = {5'h00, irq_status};
  wire [REG_W-1:0] rd_mask = {5'h00, irq_mask};
  wire [REG_W-1:0] rd_sel =
    hit_clock ? rd_clock :
    hit_low ? rd_low :
    hit_high ? rd_high :
    hit_status ? rd_status :
    hit_irq ? rd_irq :
    hit_mask ? rd_mask : 8'h00;
  wire [DATA_W-1:0] rd_word = {24'h000000, rd_sel};

  // ----------------------------------------------------------------
  // Bus slave sequencing
  // ----------------------------------------------------------------
  // Ready is registered, so every access phase lasts two cycles
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (access) begin
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= start;
      pslverr <= start & refused;
    end
  end

  // Read data is caught in the first access cycle and holds until the next read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (ce & start & ~pwrite) begin
      prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clock_sel <= RST_CLOCK_SEL;
    // quad B receive select, quad B transmit select, quad A selects
    end else if (wr_clock) begin
      clock_sel <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_low <= RST_THRESH[THR_LOW_W-1:0];
    // low threshold bits, bit 5 lowest
    end else if (wr_low) begin
      thresh_low <= pwdata[THR_LOW_LSB +: THR_LOW_W];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_high <= RST_THRESH[THR_W-1:THR_LOW_W];
      resync_ctrl <= 1'b0;
    end else if (wr_high) begin
      thresh_high <= pwdata[THR_HIGH_LSB +: THR_HIGH_W];
      resync_ctrl <= pwdata[RESYNC_BIT];
    end
  end

  // resync only on a rising change of the control bit
  // edge against registered old value, one-cycle pulse
  rise_detect u_resync_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .level(resync_ctrl),
    .pulse(resync_pulse)
  );

  // ----------------------------------------------------------------
  // Alignment status
  // ----------------------------------------------------------------
  // Overflow is sticky until the next resync; lost follows the channel logic
  // overflow flag latches, set wins over the resync clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovfl_flag <= 1'b0;
    end else if (ce) begin
      if (align_in.overflow) begin
        ovfl_flag <= 1'b1;
      end else if (resync_pulse) begin
        ovfl_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lost_flag <= 1'b0;
    end else if (ce) begin
      lost_flag <= align_in.lost;
    end
  end

  // Old flag values, so a flag that stays set raises one interrupt only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovfl_prev <= 1'b0;
      lost_prev <= 1'b0;
    end else if (ce) begin
      ovfl_prev <= ovfl_flag;
      lost_prev <= lost_flag;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // One-cycle event when a flag goes from clear to set
  function automatic logic rise_of(input logic now_val, input logic old_val);
    rise_of = now_val & ~old_val;
  endfunction

  wire [IRQ_W-1:0] irq_events =
    {resync_pulse, rise_of(lost_flag, lost_prev), rise_of(ovfl_flag, ovfl_prev)};
  wire [IRQ_W-1:0] next_irq_mask = wr_mask ? pwdata[IRQ_W-1:0] : irq_mask;
  // Set beats a same-cycle write-one clear
  wire [IRQ_W-1:0] next_irq_status =
    irq_events | (irq_status & ~(wr_irq ? pwdata[IRQ_W-1:0] : RST_IRQ));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RST_IRQ;
      irq_mask <= RST_IRQ;
    end else if (ce) begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Selects are codes only; the clock mux itself lives in the channel logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quad_a_tx_clock_source_sel <= 2'h0;
      quad_a_rx_clock_source_sel <= 2'h0;
      quad_b_tx_clock_source_sel <= 2'h0;
      quad_b_rx_clock_source_sel <= 2'h0;
    end else if (ce) begin
      quad_a_tx_clock_source_sel <= clock_sel.quad_a_tx;
      quad_a_rx_clock_source_sel <= clock_sel.quad_a_rx;
      quad_b_tx_clock_source_sel <= clock_sel.quad_b_tx;
      quad_b_rx_clock_source_sel <= clock_sel.quad_b_rx;
    end
  end

  // values above 17 are passed on unchecked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_low_threshold <= RST_THRESH;
    end else if (ce) begin
      rx_fifo_low_threshold <= {thresh_high, thresh_low};
    end
  end

  // Trigger and flags leave one cycle after the internal state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      all_channel_resync_trigger <= 1'b0;
      all_channel_align_overflow <= 1'b0;
      all_channel_align_lost <= 1'b0;
    end else if (ce) begin
      all_channel_resync_trigger <= resync_pulse;
      all_channel_align_overflow <= ovfl_flag;
      all_channel_align_lost <= lost_flag;
    end
  end

  // Mask and level move on the same edge, so no stale cycle after a mask write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

endmodule

/* tb/serdes_common_regs_chk.sv */
// Assertion checker for the common control register block
`timescale 1ns/1ps
module serdes_common_regs_chk
  import serdes_common_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire align_status_s align_in,
  input wire logic [1:0] quad_a_tx_clock_source_sel,
  input wire logic [1:0] quad_a_rx_clock_source_sel,
  input wire logic [1:0] quad_b_tx_clock_source_sel,
  input wire logic [1:0] quad_b_rx_clock_source_sel,
  input wire logic [THR_W-1:0] rx_fifo_low_threshold,
  input wire logic all_channel_resync_trigger,
  input wire logic all_channel_align_overflow,
  input wire logic all_channel_align_lost,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Frozen clock enable stalls everything, so checks pause with it
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);
  logic shadow;
  logic [2:0] rise_age;
  wire logic hi_wr = psel && penable && pready && pwrite && paddr == 20'hC2808;
  wire logic rise_w = hi_wr && pwdata[2] && !shadow;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      shadow <= 1'b0;
    else if (ce && hi_wr)
      shadow <= pwdata[2];
  end
  // Age of a rising write in enabled cycles, so a frozen stretch does not skew it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      rise_age <= 3'h0;
    else if (ce)
      rise_age <= {rise_age[1:0], rise_w};
  end
  sequence wr_s(logic [19:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence fire_s;
    ##3 all_channel_resync_trigger ##1 !all_channel_resync_trigger;
  endsequence
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  access_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  clock_select_a: assert property (
    wr_s(20'hC2800) |-> ##2 {quad_b_rx_clock_source_sel, quad_b_tx_clock_source_sel,
      quad_a_rx_clock_source_sel, quad_a_tx_clock_source_sel} == $past(pwdata[7:0], 2))
    else $error("clock source select wrong");
  thr_low_a: assert property (
    wr_s(20'hC2804) |-> ##2 rx_fifo_low_threshold[2:0] == $past(pwdata[7:5], 2))
    else $error("threshold low bits wrong");
  thr_high_a: assert property (
    wr_s(20'hC2808) |-> ##2 rx_fifo_low_threshold[4:3] == $past(pwdata[1:0], 2))
    else $error("threshold high bits wrong");
  resync_fire_a: assert property (rise_w |-> fire_s)
    else $error("resync pulse missing");
  resync_cause_a: assert property (all_channel_resync_trigger |-> rise_age[2])
    else $error("resync pulse without rising write");
  overflow_set_a: assert property (align_in.overflow |-> ##2 all_channel_align_overflow)
    else $error("overflow flag not set");
  lost_follow_a: assert property (all_channel_align_lost == $past(align_in.lost, 2))
    else $error("lost flag does not follow");
endmodule

bind serdes_common_regs serdes_common_regs_chk chk (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .align_in(align_in),
  .quad_a_tx_clock_source_sel(quad_a_tx_clock_source_sel),
  .quad_a_rx_clock_source_sel(quad_a_rx_clock_source_sel),
  .quad_b_tx_clock_source_sel(quad_b_tx_clock_source_sel),
  .quad_b_rx_clock_source_sel(quad_b_rx_clock_source_sel),
  .rx_fifo_low_threshold(rx_fifo_low_threshold),
  .all_channel_resync_trigger(all_channel_resync_trigger),
  .all_channel_align_overflow(all_channel_align_overflow),
  .all_channel_align_lost(all_channel_align_lost), .irq(irq));

/* tb/serdes_common_regs_tb.sv */
// Self-checking bench for the common control register block
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_total++; \
  $display("unexpected at %0t got %h exp %h", $time, (act), (exp)); end end
module serdes_common_regs_tb import serdes_common_pkg::*;;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic pready, pslverr, trig, ovf, lost, irq;
  logic ce = 1'b1;
  align_status_s align_in = '0;
  logic [1:0] qat, qar, qbt, qbr;
  logic [THR_W-1:0] thr;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int err_total = 0, cmp_count = 0, pulses = 0;
  integer seed = 32'h02B4D950;
  always #50 mclk = ~mclk;
  serdes_common_regs dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .align_in(align_in),
    .quad_a_tx_clock_source_sel(qat), .quad_a_rx_clock_source_sel(qar),
    .quad_b_tx_clock_source_sel(qbt), .quad_b_rx_clock_source_sel(qbr),
    .rx_fifo_low_threshold(thr), .all_channel_resync_trigger(trig),
    .all_channel_align_overflow(ovf), .all_channel_align_lost(lost), .irq(irq));
  // ----------------------------------------------------------------
  // Bus master and result watcher
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Wait for ready however long it takes; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0, {1'b0, v});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Writes leave prdata alone, so only the error bit is judged there
  always @(posedge mclk) begin
    if (rst_n && pready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, e)
    end
    if (trig === 1'b1)
      pulses++;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [4:0] tv[4];
    tv = '{5'h00, 5'h11, 5'h09, 5'h00};
    tv[3] = 5'($unsigned($random(seed)) % 18);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(20'hC2800 + 20'(4 * i), 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? {4{2'(i)}} : 8'($random(seed));
      wr(20'hC2800, {24'h0, d});
      tick(2);
      `CHK({qbr, qbt, qar, qat}, d)
      rd(20'hC2800, {24'h0, d});
    end
    foreach (tv[i]) begin
      wr(20'hC2804, {24'h0, tv[i][2:0], 5'h1F});
      wr(20'hC2808, {30'h0, tv[i][4:3]});
      tick(2);
      `CHK(thr, tv[i])
      rd(20'hC2804, {24'h0, tv[i][2:0], 5'h00});
    end
    align_in <= 2'b11;
    tick(1);
    align_in <= 2'b10;
    tick(4);
    `CHK({ovf, lost}, 2'b11)
    rd(20'hC280C, 32'h3);
    rd(20'hC2810, 32'h3);
    `CHK(irq, 1'b0)
    wr(20'hC2814, 32'h7);
    tick(2);
    `CHK(irq, 1'b1)
    wr(20'hC2810, 32'h3);
    tick(2);
    `CHK(irq, 1'b0)
    wr(20'hC2808, 32'h4);
    wr(20'hC2808, 32'h4);
    tick(4);
    rd(20'hC280C, 32'h2);
    rd(20'hC2810, 32'h4);
    rd(20'hC2808, 32'h4);
    `CHK(pulses, 1)
    wr(20'hC2808, 32'h0);
    wr(20'hC2808, 32'h4);
    tick(4);
    `CHK(pulses, 2)
    // Clock enable low must hold back the pulse of a rising write
    wr(20'hC2808, 32'h0);
    wr(20'hC2808, 32'h4);
    ce <= 1'b0;
    tick(5);
    `CHK(trig, 1'b0)
    `CHK(pulses, 2)
    ce <= 1'b1;
    tick(4);
    `CHK(pulses, 3)
    apb(1'b1, 20'hC280C, 32'h3, {1'b1, 32'h0});
    apb(1'b0, 20'hC2818, 32'h0, {1'b1, 32'h0});
    align_in <= 2'b00;
    tick(4);
    rd(20'hC280C, 32'h0);
    `CHK({ovf, lost}, 2'b00)
    final_report();
  end
endmodule
